/* File: hdl/ias_core.v */
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "ias_map.vh"

// Summary of operation
// - one active flag per priority level, four
// - return from interrupt clears serviced level
// - latch requests at periods 5, 11, 17, 23
// - source and global enable bits qualify latched requests
// - acknowledge sets level, calls, pushes pc only
// - vectoring clears timer flags and edge mode external flags
// - late requests wait one more instruction
// - vector call lasts two machine cycles
// - return or register access delays acknowledge
// - single source latency between 3 and 8 machine cycles
// - equal or higher active level blocks acknowledge
// - level mode external flag follows sampled pin
module ias_core #(
    parameter NUM_SRC = 7
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire instStart,
    input wire instEnd,
    input wire instIsReturnFromInterrupt,
    input wire instTouchesIntRegs,
    input wire extPin0N,
    input wire extPin1N,
    input wire timer0Overflow,
    input wire timer1Overflow,
    input wire serialRxTxFlags,
    input wire captureInputRequestFlag,
    input wire overflowUnderflowFlag,
    output reg callRequest,
    output reg callBusy,
    output reg pushPc,
    output reg serviceStart,
    output reg [2:0] vectorIndex,
    output reg [3:0] activeLevels
);
    // ****************************************************************
    // constants and declarations
    // ****************************************************************
    localparam [3:0] CALL_LAST = `IAS_CALL_LAST;
    localparam [3:0] PUSH_POINT = `IAS_PUSH_POINT;

    reg [7:0] interruptEnableRegister;
    reg [NUM_SRC-1:0] priorityRegisterLow;
    reg [NUM_SRC-1:0] priorityRegisterHigh;
    reg [1:0] extEdgeMode;
    reg [1:0] extPinPrev;
    reg extInt0RequestFlag;
    reg extInt1RequestFlag;
    reg timer0OverflowFlag;
    reg timer1OverflowFlag;
    reg [4:0] phase;
    reg [4:0] latchPhase;
    reg [NUM_SRC-1:0] reqLatch;
    reg [NUM_SRC-1:0] reqSettled;
    reg [3:0] callCount;
    reg [31:0] next_prdata;
    reg next_pslverr;

    wire [NUM_SRC-1:0] pending;
    wire [NUM_SRC-1:0] candidate;
    wire [NUM_SRC-1:0] qualified;
    wire [1:0] extPinN;
    wire [1:0] extFlag;
    wire latchNow;
    wire lateLatch;
    wire grantValid;
    wire [2:0] grantIndex;
    wire [1:0] grantLevel;
    wire [2:0] activeTop;
    wire ackNow;
    wire retiNow;
    wire busWrite;
    wire [3:0] swClear;
    wire [3:0] hwClear;

    // highest active level: bit 2 says any, bits 1:0 give the level
    function [2:0] topLevel;
        input [3:0] lv;
        begin
            if (lv[3]) begin
                topLevel = 3'h7;
            end else if (lv[2]) begin
                topLevel = 3'h6;
            end else if (lv[1]) begin
                topLevel = 3'h5;
            end else if (lv[0]) begin
                topLevel = 3'h4;
            end else begin
                topLevel = 3'h0;
            end
        end
    endfunction

    // one-hot of a two bit level
    function [3:0] levelBit;
        input [1:0] lv;
        begin
            levelBit = 4'h1 << lv;
        end
    endfunction

    // ****************************************************************
    // register bus
    // ****************************************************************
    // zero wait states: the access phase always completes at once
    assign pready = penable;
    assign busWrite = psel & penable & pwrite;
    assign swClear = (busWrite && paddr == `IAS_OFF_FLAGS) ? pwdata[3:0] : 4'h0;

    // read data and error are prepared in the setup cycle
    always @* begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            `IAS_OFF_ENABLE: begin
                next_prdata[7:0] = interruptEnableRegister;
            end
            `IAS_OFF_PRIO_LOW: begin
                next_prdata[NUM_SRC-1:0] = priorityRegisterLow;
            end
            `IAS_OFF_PRIO_HIGH: begin
                next_prdata[NUM_SRC-1:0] = priorityRegisterHigh;
            end
            `IAS_OFF_EXT_MODE: begin
                next_prdata[1:0] = extEdgeMode;
            end
            `IAS_OFF_FLAGS: begin
                next_prdata[NUM_SRC-1:0] = pending;
            end
            `IAS_OFF_STATUS: begin
                next_prdata[3:0] = activeLevels;
                next_prdata[`IAS_STATUS_BUSY_BIT] = callBusy;
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // read path registers
    always @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // control registers written in the access phase
    always @(posedge clk_sys) begin
        if (rst) begin
            interruptEnableRegister <= `IAS_RST_ENABLE;
            priorityRegisterLow <= `IAS_RST_PRIO;
            priorityRegisterHigh <= `IAS_RST_PRIO;
            extEdgeMode <= `IAS_RST_EXT_MODE;
        end else if (busWrite) begin
            case (paddr)
                `IAS_OFF_ENABLE: begin
                    interruptEnableRegister <= pwdata[7:0];
                end
                `IAS_OFF_PRIO_LOW: begin
                    priorityRegisterLow <= pwdata[NUM_SRC-1:0];
                end
                `IAS_OFF_PRIO_HIGH: begin
                    priorityRegisterHigh <= pwdata[NUM_SRC-1:0];
                end
                `IAS_OFF_EXT_MODE: begin
                    extEdgeMode <= pwdata[1:0];
                end
                default: begin
                    extEdgeMode <= extEdgeMode;
                end
            endcase
        end
    end

    // ****************************************************************
    // request flags
    // ****************************************************************
    assign extPinN = {extPin1N, extPin0N};
    assign extFlag = {extInt1RequestFlag, extInt0RequestFlag};

    // hardware clear on entering the routine for the four own flags
    assign hwClear[0] = serviceStart && vectorIndex == `IAS_SRC_EXT0;
    assign hwClear[1] = serviceStart && vectorIndex == `IAS_SRC_TIMER0;
    assign hwClear[2] = serviceStart && vectorIndex == `IAS_SRC_EXT1;
    assign hwClear[3] = serviceStart && vectorIndex == `IAS_SRC_TIMER1;

    // pins are synchronous, so the previous sample serves edge detection
    always @(posedge clk_sys) begin
        if (rst) begin
            extPinPrev <= 2'h3;
        end else begin
            extPinPrev <= extPinN;
        end
    end

    // external flags: level mode tracks the pin, edge mode is sticky
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : extGen
            wire fallEdge;
            reg flagQ;
            assign fallEdge = extPinPrev[g] & ~extPinN[g];
            always @(posedge clk_sys) begin
                if (rst) begin
                    flagQ <= 1'b0;
                end else if (!extEdgeMode[g]) begin
                    flagQ <= ~extPinN[g];
                end else if (fallEdge) begin
                    flagQ <= 1'b1; // set wins over any clear
                end else if (hwClear[2 * g] || swClear[2 * g]) begin
                    flagQ <= 1'b0;
                end
            end
        end
    endgenerate

    // flag names for the rest of the block
    always @* begin
        extInt0RequestFlag = extGen[0].flagQ;
        extInt1RequestFlag = extGen[1].flagQ;
    end

    // timer overflow flags, cleared by vectoring or by software
    always @(posedge clk_sys) begin
        if (rst) begin
            timer0OverflowFlag <= 1'b0;
            timer1OverflowFlag <= 1'b0;
        end else begin
            if (timer0Overflow) begin
                timer0OverflowFlag <= 1'b1;
            end else if (hwClear[1] || swClear[1]) begin
                timer0OverflowFlag <= 1'b0;
            end
            if (timer1Overflow) begin
                timer1OverflowFlag <= 1'b1;
            end else if (hwClear[3] || swClear[3]) begin
                timer1OverflowFlag <= 1'b0;
            end
        end
    end

    // serial, capture and overflow flags live in their peripherals and
    // are never cleared here; their routines must clear them
    assign pending = {overflowUnderflowFlag, captureInputRequestFlag, serialRxTxFlags,
        timer1OverflowFlag, extFlag[1], timer0OverflowFlag, extFlag[0]};

    // ****************************************************************
    // instruction phase and request latch
    // ****************************************************************
    // phase 1 is the first oscillator period of an instruction
    always @(posedge clk_sys) begin
        if (rst) begin
            phase <= 5'h00;
        end else if (instStart) begin
            phase <= 5'h01;
        end else if (phase != `IAS_PHASE_MAX) begin
            phase <= phase + 5'h01;
        end
    end

    assign latchNow = phase == `IAS_LATCH_A || phase == `IAS_LATCH_B ||
        phase == `IAS_LATCH_C || phase == `IAS_LATCH_D;

    // the older latch is kept so a late capture can be passed over
    always @(posedge clk_sys) begin
        if (rst) begin
            reqLatch <= {NUM_SRC{1'b0}};
            reqSettled <= {NUM_SRC{1'b0}};
            latchPhase <= 5'h00;
        end else if (latchNow) begin
            reqSettled <= reqLatch;
            reqLatch <= pending;
            latchPhase <= phase;
        end
    end

    // a capture inside the last seven periods waits for the next end
    assign lateLatch = (phase - latchPhase) < `IAS_DEFER_PERIODS;
    assign candidate = lateLatch ? reqSettled : reqLatch;

    // ****************************************************************
    // qualification and selection
    // ****************************************************************
    assign qualified = candidate & interruptEnableRegister[NUM_SRC-1:0] &
        {NUM_SRC{interruptEnableRegister[`IAS_GLOBAL_EN_BIT]}};

    ias_prio_select #(
        .NUM_SRC(NUM_SRC)
    ) uSelect (
        .qualified(qualified),
        .levelLow(priorityRegisterLow),
        .levelHigh(priorityRegisterHigh),
        .grantValid(grantValid),
        .grantIndex(grantIndex),
        .grantLevel(grantLevel)
    );

    assign activeTop = topLevel(activeLevels);

    // acknowledge only at an instruction end, never right after a
    // return or an enable/priority access, and only above the active level
    assign ackNow = instEnd && !callBusy && grantValid &&
        !instIsReturnFromInterrupt && !instTouchesIntRegs &&
        (!activeTop[2] || grantLevel > activeTop[1:0]);
    assign retiNow = instEnd && !callBusy && instIsReturnFromInterrupt;

    // ****************************************************************
    // level flags and vector call
    // ****************************************************************
    // four level flags; the top one is the level being serviced
    always @(posedge clk_sys) begin
        if (rst) begin
            activeLevels <= 4'h0;
        end else if (ackNow) begin
            activeLevels <= activeLevels | levelBit(grantLevel);
        end else if (retiNow && activeTop[2]) begin
            activeLevels <= activeLevels & ~levelBit(activeTop[1:0]);
        end
    end

    // the call occupies two machine cycles; only the pc is pushed,
    // status word saving is left to the routine
    always @(posedge clk_sys) begin
        if (rst) begin
            callBusy <= 1'b0;
            callCount <= 4'h0;
            callRequest <= 1'b0;
            pushPc <= 1'b0;
            serviceStart <= 1'b0;
            vectorIndex <= 3'h0;
        end else begin
            callRequest <= ackNow;
            pushPc <= callBusy && callCount == PUSH_POINT - 4'h1;
            serviceStart <= callBusy && callCount == CALL_LAST;
            if (ackNow) begin
                callBusy <= 1'b1;
                callCount <= 4'h0;
                vectorIndex <= grantIndex;
            end else if (callBusy) begin
                if (callCount == CALL_LAST) begin
                    callBusy <= 1'b0;
                    callCount <= 4'h0;
                end else begin
                    callCount <= callCount + 4'h1;
                end
            end
        end
    end
endmodule // ias_core

/* File: hdl/ias_prio_select.v */
`timescale 1ns/1ns
`include "ias_map.vh"

// ****************************************************************
// fixed-order priority selector
// ****************************************************************
// highest level wins; within a level the lowest source index wins
module ias_prio_select #(
    parameter NUM_SRC = 7
) (
    input wire [NUM_SRC-1:0] qualified,
    input wire [NUM_SRC-1:0] levelLow,
    input wire [NUM_SRC-1:0] levelHigh,
    output reg grantValid,
    output reg [2:0] grantIndex,
    output reg [1:0] grantLevel
);
    integer i;

    // scan downward so an equal level at a lower index replaces the pick
    always @* begin
        grantValid = 1'b0;
        grantIndex = 3'h0;
        grantLevel = 2'h0;
        for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (qualified[i] && (!grantValid || {levelHigh[i], levelLow[i]} >= grantLevel)) begin
                grantValid = 1'b1;
                grantIndex = i[2:0];
                grantLevel = {levelHigh[i], levelLow[i]};
            end
        end
    end
endmodule // ias_prio_select

/* File: shared/ias_map.vh */
// ****************************************************************
// register map, reset values and timing of the acknowledge sequencer
// ****************************************************************
`ifndef IAS_MAP_VH
`define IAS_MAP_VH

// byte offsets on the register bus
`define IAS_OFF_ENABLE 8'h00
`define IAS_OFF_PRIO_LOW 8'h04
`define IAS_OFF_PRIO_HIGH 8'h08
`define IAS_OFF_EXT_MODE 8'h0c
`define IAS_OFF_FLAGS 8'h10
`define IAS_OFF_STATUS 8'h14

// reset values
`define IAS_RST_ENABLE 8'h00
`define IAS_RST_PRIO 7'h00
`define IAS_RST_EXT_MODE 2'h0

// field positions
`define IAS_GLOBAL_EN_BIT 7
`define IAS_STATUS_BUSY_BIT 4
`define IAS_HW_FLAG_BITS 4

// source indices, also the fixed polling order within a level
`define IAS_SRC_EXT0 3'h0
`define IAS_SRC_TIMER0 3'h1
`define IAS_SRC_EXT1 3'h2
`define IAS_SRC_TIMER1 3'h3
`define IAS_SRC_SERIAL 3'h4
`define IAS_SRC_CAPTURE 3'h5
`define IAS_SRC_OVUN 3'h6

// oscillator periods of the instruction in which requests are latched
`define IAS_LATCH_A 5'h05
`define IAS_LATCH_B 5'h0b
`define IAS_LATCH_C 5'h11
`define IAS_LATCH_D 5'h17
`define IAS_PHASE_MAX 5'h1f

// a request latched within this many final periods waits one instruction
`define IAS_DEFER_PERIODS 5'h07

// one oscillator period is one clk_sys cycle (50 ns at 20 MHz)
`define IAS_MC_CLOCKS 6
`define IAS_CALL_MC 2
`define IAS_CALL_CLOCKS (`IAS_MC_CLOCKS * `IAS_CALL_MC)
// call counter values, sized for the four bit counter
`define IAS_CALL_LAST 4'hb
`define IAS_PUSH_POINT 4'h5

`endif

/* File: testbench/ias_core_props.sv */
`timescale 1ns/1ns

// ****
// acknowledge sequencer checks
// ****
module ias_core_props #(
    parameter NUM_SRC = 7
) (
    input wire clk_sys,
    input wire rst,
    input wire instEnd,
    input wire instIsReturnFromInterrupt,
    input wire instTouchesIntRegs,
    input wire callRequest,
    input wire callBusy,
    input wire pushPc,
    input wire serviceStart,
    input wire [3:0] activeLevels
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // busy for exactly twelve clocks, then the entry pulse with busy gone
    property p_callLen;
        callRequest |-> callBusy[*8] ##1 callBusy[*4] ##1 (serviceStart && !callBusy);
    endproperty
    a_callLen: assert property (p_callLen) else $error("vector call length wrong");
    property p_busyCause;
        $rose(callBusy) |-> callRequest;
    endproperty
    a_busyCause: assert property (p_busyCause) else $error("busy without call");
    property p_push;
        callRequest |-> ##5 pushPc;
    endproperty
    a_push: assert property (p_push) else $error("pc push missing");
    property p_ackPoint;
        callRequest |-> $past(instEnd) && !$past(instIsReturnFromInterrupt)
            && !$past(instTouchesIntRegs);
    endproperty
    a_ackPoint: assert property (p_ackPoint) else $error("call at wrong point");
    property p_noNest;
        callRequest |-> !$past(callBusy);
    endproperty
    a_noNest: assert property (p_noNest) else $error("call during call");
    property p_retClr;
        instEnd && instIsReturnFromInterrupt && !callBusy && activeLevels != 4'h0
            |=> $countones(activeLevels) == $countones($past(activeLevels)) - 1;
    endproperty
    a_retClr: assert property (p_retClr) else $error("return kept level");
    property p_topBlk;
        callRequest |-> !$past(activeLevels[3]);
    endproperty
    a_topBlk: assert property (p_topBlk) else $error("top level preempted");
    property p_entry;
        serviceStart |-> $past(callBusy);
    endproperty
    a_entry: assert property (p_entry) else $error("entry without call");
    c_call: cover property (callRequest);
    c_nest: cover property (activeLevels == 4'h9);
    c_ret: cover property (instEnd && instIsReturnFromInterrupt && activeLevels != 4'h0);
endmodule // ias_core_props

bind ias_core ias_core_props #(.NUM_SRC(NUM_SRC)) uProps (
    .clk_sys(clk_sys),
    .rst(rst),
    .instEnd(instEnd),
    .instIsReturnFromInterrupt(instIsReturnFromInterrupt),
    .instTouchesIntRegs(instTouchesIntRegs),
    .callRequest(callRequest),
    .callBusy(callBusy),
    .pushPc(pushPc),
    .serviceStart(serviceStart),
    .activeLevels(activeLevels)
);

/* File: testbench/ias_seq_model.sv */
`timescale 1ns/1ns

// ****
// instruction sequencer model
// ****
module ias_seq_model (
    input wire clk_sys,
    input wire rst,
    input wire callBusy,
    input wire [4:0] cfgLen,
    input wire cfgRet,
    input wire cfgTouch,
    output logic instStart,
    output logic instEnd,
    output logic instIsReturnFromInterrupt,
    output logic instTouchesIntRegs
);
    int len;
    // config sampled one cycle in, so the bench may drop it at the previous end
    initial begin
        instStart = 1'b0;
        instEnd = 1'b0;
        instIsReturnFromInterrupt = 1'b0;
        instTouchesIntRegs = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (!rst && !callBusy) begin
                instStart <= 1'b1;
                @(posedge clk_sys);
                instStart <= 1'b0;
                len = cfgLen;
                instIsReturnFromInterrupt <= cfgRet;
                instTouchesIntRegs <= cfgTouch;
                repeat (len - 1) @(posedge clk_sys); // end is sampled on phase len
                instEnd <= 1'b1;
                @(posedge clk_sys);
                instEnd <= 1'b0;
                instIsReturnFromInterrupt <= 1'b0;
                instTouchesIntRegs <= 1'b0;
            end
        end
    end
endmodule // ias_seq_model

/* File: testbench/interrupt_ack_sequencer_test.sv */
`timescale 1ns/1ns
`include "ias_map.vh"

// ****
// acknowledge sequencer bench
// ****
module interrupt_ack_sequencer_test;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err, cfgRet, cfgTouch;
    logic extPin0N, extPin1N, timer0Overflow, timer1Overflow, serRx, capIn, ovUn;
    logic instStart, instEnd, instRet, instTouch, callRequest, callBusy, pushPc, svc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] vectorIndex, m;
    logic [3:0] activeLevels;
    logic [4:0] cfgLen;
    int fail_count, checks, cycles, lat, n, i;
    ias_core dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instStart(instStart), .instEnd(instEnd),
        .instIsReturnFromInterrupt(instRet), .instTouchesIntRegs(instTouch),
        .extPin0N(extPin0N), .extPin1N(extPin1N), .timer0Overflow(timer0Overflow),
        .timer1Overflow(timer1Overflow), .serialRxTxFlags(serRx),
        .captureInputRequestFlag(capIn), .overflowUnderflowFlag(ovUn),
        .callRequest(callRequest), .callBusy(callBusy), .pushPc(pushPc),
        .serviceStart(svc), .vectorIndex(vectorIndex), .activeLevels(activeLevels));
    ias_seq_model model (.clk_sys(clk_sys), .rst(rst), .callBusy(callBusy),
        .cfgLen(cfgLen), .cfgRet(cfgRet), .cfgTouch(cfgTouch), .instStart(instStart),
        .instEnd(instEnd), .instIsReturnFromInterrupt(instRet),
        .instTouchesIntRegs(instTouch));
    // clock and hang guard; the tests need only a few thousand cycles
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            complete_run;
        end
    end
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks++;
            if (seen !== exp) begin
                fail_count++;
                $display("unexpected %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one apb transfer; an idle cycle after keeps psel from being set twice in a step
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        begin
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            psel <= 1'b1;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1) @(posedge clk_sys);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task waitCall(input int limit);
        begin
            lat = 0;
            while (callRequest !== 1'b1 && lat < limit) begin
                @(posedge clk_sys);
                lat++;
            end
        end
    endtask
    // waits for the routine entry, then one edge so its updates have landed
    task waitSvc;
        begin
            n = 0;
            while (svc !== 1'b1 && n < 40) begin
                @(posedge clk_sys);
                n++;
            end
            fail_count += (n == 40);
            @(posedge clk_sys);
        end
    endtask
    task retInstr(input logic [3:0] expLv);
        begin
            cfgRet <= 1'b1;
            n = 0;
            while (!(instEnd === 1'b1 && instRet === 1'b1) && n < 200) begin
                @(posedge clk_sys);
                n++;
            end
            cfgRet <= 1'b0;
            fail_count += (n == 200);
            @(posedge clk_sys);
            check("levelsAfterReturn", activeLevels, expLv);
        end
    endtask
    task pulse0;
        begin
            timer0Overflow <= 1'b1;
            @(posedge clk_sys);
            timer0Overflow <= 1'b0;
        end
    endtask
    function automatic logic [2:0] firstSet(input logic [2:0] v);
        firstSet = v[0] ? 3'h4 : (v[1] ? 3'h5 : 3'h6);
    endfunction
    initial begin
        {psel, penable, pwrite, timer0Overflow, timer1Overflow, serRx, capIn, ovUn} = 8'h00;
        {extPin0N, extPin1N, rst, cfgRet, cfgTouch} = 5'h1c;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfgLen = 5'h06;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        void'($urandom(32'h979e2f10));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        apb(`IAS_OFF_ENABLE, 1'b0, 32'h0);
        check("enableReset", rd, 32'h0);
        apb(`IAS_OFF_STATUS, 1'b0, 32'h0);
        check("statusReset", rd, 32'h0);
        apb(8'hfc, 1'b0, 32'h0);
        check("unmappedErr", {31'h0, err}, 32'h1);
        extPin0N <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(`IAS_OFF_FLAGS, 1'b0, 32'h0);
        check("levelFlagLow", rd & 32'h1, 32'h1);
        extPin0N <= 1'b1;
        // long enough for stale latches of the low pin to age out before enabling
        repeat (20) @(posedge clk_sys);
        apb(`IAS_OFF_FLAGS, 1'b0, 32'h0);
        check("levelFlagHigh", rd & 32'h1, 32'h0);
        $display("test registers done");
        // single source latency over random instruction lengths
        apb(`IAS_OFF_ENABLE, 1'b1, 32'h81);
        for (i = 0; i < 6; i++) begin
            cfgLen <= 5'(6 * (1 + $urandom % 4));
            repeat ($urandom % 30) @(posedge clk_sys);
            extPin0N <= 1'b0;
            waitCall(100);
            extPin0N <= 1'b1;
            waitSvc;
            check("latencyInRange", {31'h0, lat + n > 18 && lat + n < 48}, 32'h1);
            check("vectorExt0", {29'h0, vectorIndex}, 32'h0);
            check("levelSet", activeLevels, 4'h1);
            retInstr(4'h0);
        end
        $display("test latency done");
        // level sources stay pending until software clears them
        cfgLen <= 5'h0c;
        apb(`IAS_OFF_ENABLE, 1'b1, 32'hf0);
        for (i = 0; i < 3; i++) begin
            m = 3'(1 + $urandom % 7);
            {ovUn, capIn, serRx} <= m;
            waitCall(100);
            waitSvc;
            check("pollOrder", {29'h0, vectorIndex}, {29'h0, firstSet(m)});
            apb(`IAS_OFF_FLAGS, 1'b0, 32'h0);
            check("softFlags", (rd >> 4) & 32'h7, {29'h0, m});
            {ovUn, capIn, serRx} <= 3'h0;
            retInstr(4'h0);
        end
        $display("test polling done");
        // nesting: level 0 timer blocked by itself, preempted by level 3 timer
        apb(`IAS_OFF_ENABLE, 1'b1, 32'h8a);
        apb(`IAS_OFF_PRIO_LOW, 1'b1, 32'h08);
        apb(`IAS_OFF_PRIO_HIGH, 1'b1, 32'h08);
        pulse0;
        waitCall(100);
        waitSvc;
        check("vectorTmr0", {29'h0, vectorIndex}, 32'h1);
        apb(`IAS_OFF_FLAGS, 1'b0, 32'h0);
        check("tmr0Cleared", rd & 32'h2, 32'h0);
        pulse0;
        waitCall(150);
        check("sameLevelWaits", lat, 150);
        timer1Overflow <= 1'b1;
        @(posedge clk_sys);
        timer1Overflow <= 1'b0;
        waitCall(100);
        waitSvc;
        check("vectorTmr1", {29'h0, vectorIndex}, 32'h3);
        check("levelsNested", activeLevels, 4'h9);
        retInstr(4'h1);
        retInstr(4'h0);
        waitCall(100);
        waitSvc;
        check("vectorTmr0Late", {29'h0, vectorIndex}, 32'h1);
        retInstr(4'h0);
        $display("test nesting done");
        // global enable off, then register-touching instructions hold the call back
        apb(`IAS_OFF_ENABLE, 1'b1, 32'h04);
        extPin1N <= 1'b0;
        waitCall(150);
        check("globalOffWaits", lat, 150);
        cfgTouch <= 1'b1;
        // enable only inside a touching instruction, as the write itself would be
        while (instTouch !== 1'b1) @(posedge clk_sys);
        apb(`IAS_OFF_ENABLE, 1'b1, 32'h84);
        waitCall(150);
        check("touchWaits", lat, 150);
        cfgTouch <= 1'b0;
        waitCall(150);
        extPin1N <= 1'b1;
        waitSvc;
        check("vectorExt1", {29'h0, vectorIndex}, 32'h2);
        retInstr(4'h0);
        $display("test hold-off done");
        complete_run;
    end
endmodule // interrupt_ack_sequencer_test
